// [hw/eswfr_ctrl.sv]
// Purpose: processor-side controller for data array writes and program reads
// Assumes: core issues at most one register write per cycle on cpu_wr_in
// Notes: rst_in is the power-up reset; abort_rst_in is a later reset
`timescale 1ns/1ps
`default_nettype none
`include "eswfr_params.svh"

module eswfr_ctrl #(
    parameter int WRITE_CYCLES = `ESWFR_WRITE_CYCLES,
    parameter int PWRT_CYCLES = `ESWFR_PWRT_CYCLES
) (
    input wire logic clk_in, // core clock
    input wire logic rst_in, // power-up reset
    input wire logic abort_rst_in, // external or watchdog reset
    input wire eswfr_pkg::eswfr_cpu_wr_t cpu_wr_in, // register write
    input wire logic done_clr_in, // clear write-done flag
    input wire logic prog_we_in, // program array load strobe
    input wire logic [11:0] prog_addr_in, // program array load address
    input wire logic [13:0] prog_data_in, // program array load word
    output logic [7:0] addr_low_reg_out, // low address byte
    output logic [3:0] addr_high_reg_out, // high address bits
    output logic [7:0] data_low_reg_out, // low data byte
    output logic [5:0] data_high_reg_out, // high data bits
    output var eswfr_pkg::eswfr_ctrl_t nv_control_reg_out, // control bits
    output logic write_done_flag_out, // sticky write-done flag
    output logic stall_out, // discard instruction in this slot
    output logic pwrt_busy_out // power-up timer running
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam int PW = $clog2(PWRT_CYCLES + 1);

    if (WRITE_CYCLES < 1 || PWRT_CYCLES < 1) begin : g_chk
        $error("eswfr_ctrl: cycle counts must be at least one");
    end

    logic [7:0] addr_low_reg;
    logic [3:0] addr_high_reg;
    logic [7:0] data_low_reg;
    logic [5:0] data_high_reg;
    eswfr_pkg::eswfr_ctrl_t ctrl;
    logic wr_start, rd_start, space_sel, permit, abort_flag;
    logic write_done_flag;
    logic stall;
    eswfr_pkg::eswfr_state_t state;
    eswfr_pkg::eswfr_unlock_t unlock;
    logic [CW-1:0] cnt;
    logic [PW-1:0] pwrt_cnt;
    logic pwrt_busy;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] ee_q;
    logic [13:0] fl_q;

    logic ctrl_we;
    logic unlock_we;
    logic start_write;
    logic start_read;
    logic write_end;
    logic ee_re;
    logic fl_re;

    assign ctrl_we = cpu_wr_in.we && cpu_wr_in.sel == eswfr_pkg::ESWFR_SEL_CONTROL;
    assign unlock_we = cpu_wr_in.we && cpu_wr_in.sel == eswfr_pkg::ESWFR_SEL_UNLOCK;
    // permit must already be set; program space leaves write-start at zero
    assign start_write = ctrl_we && cpu_wr_in.data[`ESWFR_BIT_WR] && !abort_rst_in
        && state == eswfr_pkg::ESWFR_ST_IDLE && unlock == eswfr_pkg::ESWFR_U_ARMED
        && ctrl.write_permit_bit
        && !cpu_wr_in.data[`ESWFR_BIT_SPACE]
        && !pwrt_busy;
    assign start_read = ctrl_we && cpu_wr_in.data[`ESWFR_BIT_RD] && !abort_rst_in
        && state == eswfr_pkg::ESWFR_ST_IDLE && !start_write;
    assign write_end = state == eswfr_pkg::ESWFR_ST_WRITE && cnt == '0 && !abort_rst_in;
    assign ee_re = state == eswfr_pkg::ESWFR_ST_RD_WAIT && !ctrl.space_select_bit;
    assign fl_re = state == eswfr_pkg::ESWFR_ST_RD_WAIT && ctrl.space_select_bit;

    // power-up timer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwrt_cnt <= '0;
            pwrt_busy <= 1'b1;
        end else if (pwrt_busy) begin
            pwrt_cnt <= pwrt_cnt + PW'(1);
            pwrt_busy <= pwrt_cnt != PW'(PWRT_CYCLES - 1);
        end
    end

    // unlock tracker
    always_ff @(posedge clk_in) begin
        if (rst_in || abort_rst_in) begin
            unlock <= eswfr_pkg::ESWFR_U_IDLE;
        end else if (unlock_we) begin
            case (unlock)
                eswfr_pkg::ESWFR_U_IDLE: begin
                    unlock <= cpu_wr_in.data == `ESWFR_UNLOCK_KEY1 ? eswfr_pkg::ESWFR_U_GOT_KEY1
                        : eswfr_pkg::ESWFR_U_IDLE;
                end
                eswfr_pkg::ESWFR_U_GOT_KEY1: begin
                    unlock <= cpu_wr_in.data == `ESWFR_UNLOCK_KEY2 ? eswfr_pkg::ESWFR_U_ARMED
                        : eswfr_pkg::ESWFR_U_IDLE;
                end
                default: begin
                    unlock <= eswfr_pkg::ESWFR_U_IDLE;
                end
            endcase
        end else if (cpu_wr_in.we) begin
            unlock <= eswfr_pkg::ESWFR_U_IDLE;
        end
    end

    // sequencer and write-start, read-start bits
    always_ff @(posedge clk_in) begin
        if (rst_in || abort_rst_in) begin
            state <= eswfr_pkg::ESWFR_ST_IDLE;
            wr_start <= 1'b0;
            rd_start <= 1'b0;
            cnt <= '0;
            stall <= 1'b0;
        end else begin
            case (state)
                eswfr_pkg::ESWFR_ST_IDLE: begin
                    if (start_write) begin
                        state <= eswfr_pkg::ESWFR_ST_WRITE;
                        wr_start <= 1'b1;
                        cnt <= CW'(WRITE_CYCLES - 1);
                    end else if (start_read) begin
                        state <= eswfr_pkg::ESWFR_ST_RD_WAIT;
                        rd_start <= 1'b1;
                    end
                end
                eswfr_pkg::ESWFR_ST_RD_WAIT: begin
                    state <= eswfr_pkg::ESWFR_ST_RD_ACCESS;
                    stall <= ctrl.space_select_bit;
                end
                eswfr_pkg::ESWFR_ST_RD_ACCESS: begin
                    state <= eswfr_pkg::ESWFR_ST_IDLE;
                    rd_start <= 1'b0;
                    stall <= 1'b0;
                end
                eswfr_pkg::ESWFR_ST_WRITE: begin
                    if (cnt == '0) begin
                        state <= eswfr_pkg::ESWFR_ST_IDLE;
                        wr_start <= 1'b0;
                    end else begin
                        cnt <= cnt - CW'(1);
                    end
                end
                default: begin
                    state <= eswfr_pkg::ESWFR_ST_IDLE;
                end
            endcase
        end
    end

    // software-owned control bits
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            space_sel <= 1'b0;
            permit <= 1'b0;
            abort_flag <= 1'b0;
        end else if (abort_rst_in) begin
            space_sel <= 1'b0;
            permit <= 1'b0;
            abort_flag <= state == eswfr_pkg::ESWFR_ST_WRITE
                || abort_flag;
        end else if (ctrl_we) begin
            space_sel <= cpu_wr_in.data[`ESWFR_BIT_SPACE];
            permit <= cpu_wr_in.data[`ESWFR_BIT_PERMIT];
            abort_flag <= cpu_wr_in.data[`ESWFR_BIT_ABORT];
        end
    end

    // sticky done flag, set wins over clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            write_done_flag <= 1'b0;
        end else if (write_end) begin
            write_done_flag <= 1'b1;
        end else if (done_clr_in) begin
            write_done_flag <= 1'b0;
        end
    end

    // address and data registers; an abort leaves them unchanged
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            addr_low_reg <= `ESWFR_RST_BYTE;
            addr_high_reg <= `ESWFR_RST_HIGH_ADDR;
            data_low_reg <= `ESWFR_RST_BYTE;
            data_high_reg <= `ESWFR_RST_HIGH_DATA;
        end else if (state == eswfr_pkg::ESWFR_ST_RD_ACCESS && !abort_rst_in) begin
            data_low_reg <= ctrl.space_select_bit ? fl_q[7:0] : ee_q;
            if (ctrl.space_select_bit) begin
                data_high_reg <= fl_q[13:8];
            end
        end else if (cpu_wr_in.we && !abort_rst_in) begin
            case (cpu_wr_in.sel)
                eswfr_pkg::ESWFR_SEL_ADDR_LOW: addr_low_reg <= cpu_wr_in.data;
                eswfr_pkg::ESWFR_SEL_ADDR_HIGH: addr_high_reg <= cpu_wr_in.data[3:0];
                eswfr_pkg::ESWFR_SEL_DATA_LOW: data_low_reg <= cpu_wr_in.data;
                eswfr_pkg::ESWFR_SEL_DATA_HIGH: data_high_reg <= cpu_wr_in.data[5:0];
                default: begin
                end
            endcase
        end
    end

    // target latched at start so later register writes cannot alter the cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_addr <= `ESWFR_RST_BYTE;
            wr_data <= `ESWFR_RST_BYTE;
        end else if (start_write) begin
            wr_addr <= addr_low_reg;
            wr_data <= data_low_reg;
        end
    end

    eswfr_mem #(.WIDTH(8), .DEPTH(`ESWFR_EE_DEPTH)) u_ee (
        .clk_in(clk_in),
        .we_in(write_end),
        .re_in(ee_re),
        .addr_in(write_end ? wr_addr : addr_low_reg),
        .wdata_in(wr_data),
        .rdata_out(ee_q)
    );

    eswfr_mem #(.WIDTH(`ESWFR_FLASH_WIDTH), .DEPTH(`ESWFR_FLASH_DEPTH)) u_flash (
        .clk_in(clk_in),
        .we_in(prog_we_in),
        .re_in(fl_re),
        .addr_in(prog_we_in ? prog_addr_in : {addr_high_reg, addr_low_reg}),
        .wdata_in(prog_data_in),
        .rdata_out(fl_q)
    );

    assign addr_low_reg_out = addr_low_reg;
    assign addr_high_reg_out = addr_high_reg;
    assign data_low_reg_out = data_low_reg;
    assign data_high_reg_out = data_high_reg;
    assign ctrl = {space_sel, abort_flag, permit, wr_start, rd_start};
    assign nv_control_reg_out = ctrl;
    assign write_done_flag_out = write_done_flag;
    assign stall_out = stall;
    assign pwrt_busy_out = pwrt_busy;

    // checks
    int unsigned wr_age;
    always_ff @(posedge clk_in) begin
        if (rst_in || !ctrl.write_start) begin
            wr_age <= 0;
        end else begin
            wr_age <= wr_age + 1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence prog_read_start_s;
        $rose(ctrl.read_start) && ctrl.space_select_bit;
    endsequence
    sequence stolen_slot_s;
        !stall ##1 stall ##1 !stall;
    endsequence

    unlock_guard_a: assert property ($rose(ctrl.write_start) |->
        $past(unlock) == eswfr_pkg::ESWFR_U_ARMED && $past(ctrl.write_permit_bit) && !$past(pwrt_busy))
        else $error("write started without unlock, permit or timer expiry");
    permit_hold_a: assert property (write_end && !ctrl_we |=> $stable(ctrl.write_permit_bit))
        else $error("write-permit changed by write completion");
    write_length_a: assert property ($fell(ctrl.write_start) && !$past(abort_rst_in) |->
        $past(wr_age) == WRITE_CYCLES - 1)
        else $error("write-start did not last the write cycle length");
    done_set_a: assert property ($fell(ctrl.write_start) && !$past(abort_rst_in) |-> write_done_flag)
        else $error("write-done flag not set at write end");
    done_sticky_a: assert property (write_done_flag && !done_clr_in |=> write_done_flag)
        else $error("write-done flag cleared by hardware");
    prog_no_write_a: assert property (ctrl_we && cpu_wr_in.data[`ESWFR_BIT_SPACE] |=> !$rose(ctrl.write_start))
        else $error("write started with program space selected");
    stolen_slot_a: assert property (prog_read_start_s |-> stolen_slot_s)
        else $error("program read did not steal the second slot");
    word_ready_a: assert property ($rose(stall) |=> data_low_reg == $past(fl_q[7:0])
        && data_high_reg == $past(fl_q[13:8]))
        else $error("program word not in data registers");
    abort_flag_a: assert property (abort_rst_in && state == eswfr_pkg::ESWFR_ST_WRITE |=>
        ctrl.write_abort_flag && $stable(addr_low_reg) && $stable(data_low_reg))
        else $error("abort flag missing or registers changed");
    pwrt_block_a: assert property (pwrt_busy |=> !$rose(ctrl.write_start))
        else $error("write started during power-up timer");
    por_clear_a: assert property ($past(rst_in) |-> !ctrl.write_permit_bit && !ctrl.write_start)
        else $error("write-permit not clear after power-up");
endmodule : eswfr_ctrl
`default_nettype wire

// [hw/eswfr_mem.sv]
// Purpose: single-port array with registered read data
// Assumes: one access per cycle, write has priority
// Notes: used for both the data array and the program array
`timescale 1ns/1ps
`default_nettype none
module eswfr_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_in, // core clock
    input wire logic we_in, // write strobe
    input wire logic re_in, // read strobe
    input wire logic [AW-1:0] addr_in, // word address
    input wire logic [WIDTH-1:0] wdata_in, // write data
    output logic [WIDTH-1:0] rdata_out // registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (WIDTH < 1 || DEPTH < 2) begin : g_chk
        $error("eswfr_mem: bad geometry");
    end

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (re_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule : eswfr_mem
`default_nettype wire

// [hw/eswfr_params.svh]
// Purpose: constants for the nonvolatile access controller
// Assumes: core clock of 40 MHz
// Notes: offsets are bit positions of the control byte
`ifndef ESWFR_PARAMS_SVH
`define ESWFR_PARAMS_SVH

`define ESWFR_CLK_HZ 40000000
`define ESWFR_PWRT_MS 64
`define ESWFR_PWRT_CYCLES (`ESWFR_PWRT_MS * (`ESWFR_CLK_HZ / 1000))
`define ESWFR_WRITE_CYCLES 200
`define ESWFR_EE_DEPTH 256
`define ESWFR_FLASH_DEPTH 4096
`define ESWFR_FLASH_WIDTH 14

`define ESWFR_UNLOCK_KEY1 8'h55
`define ESWFR_UNLOCK_KEY2 8'haa

`define ESWFR_BIT_RD 0
`define ESWFR_BIT_WR 1
`define ESWFR_BIT_PERMIT 2
`define ESWFR_BIT_ABORT 3
`define ESWFR_BIT_SPACE 7

`define ESWFR_RST_BYTE 8'h00
`define ESWFR_RST_HIGH_ADDR 4'h0
`define ESWFR_RST_HIGH_DATA 6'h00

`endif

// [hw/eswfr_pkg.sv]
// Purpose: types shared by the nonvolatile access controller
// Assumes: nothing
// Notes: constants live in eswfr_params.svh
package eswfr_pkg;

    typedef enum logic [2:0] {
        ESWFR_SEL_ADDR_LOW = 3'h0,
        ESWFR_SEL_ADDR_HIGH = 3'h1,
        ESWFR_SEL_DATA_LOW = 3'h2,
        ESWFR_SEL_DATA_HIGH = 3'h3,
        ESWFR_SEL_CONTROL = 3'h4,
        ESWFR_SEL_UNLOCK = 3'h5
    } eswfr_sel_t;

    typedef struct packed {
        logic we;
        eswfr_sel_t sel;
        logic [7:0] data;
    } eswfr_cpu_wr_t;

    typedef struct packed {
        logic space_select_bit;
        logic write_abort_flag;
        logic write_permit_bit;
        logic write_start;
        logic read_start;
    } eswfr_ctrl_t;

    typedef enum logic [1:0] {
        ESWFR_U_IDLE = 2'h0,
        ESWFR_U_GOT_KEY1 = 2'h1,
        ESWFR_U_ARMED = 2'h2
    } eswfr_unlock_t;

    typedef enum logic [1:0] {
        ESWFR_ST_IDLE = 2'h0,
        ESWFR_ST_RD_WAIT = 2'h1,
        ESWFR_ST_RD_ACCESS = 2'h2,
        ESWFR_ST_WRITE = 2'h3
    } eswfr_state_t;

endpackage : eswfr_pkg

// [tb/eswfr_ctrl_test.sv]
// Purpose: self-checking bench for the nonvolatile access controller
// Assumes: shortened write and power-up counts, one register write every other cycle
// Notes: model keeps array contents in integer maps filled by the bench
`timescale 1ns/1ps
`default_nettype none
`include "eswfr_params.svh"
module eswfr_ctrl_test;
    localparam int WC = 20;
    localparam int PW = 40;
    logic clk_in;
    logic rst_in;
    logic abort_rst_in;
    eswfr_pkg::eswfr_cpu_wr_t cpu_wr_in;
    logic done_clr_in;
    logic prog_we_in;
    logic [11:0] prog_addr_in;
    logic [13:0] prog_data_in;
    logic [7:0] addr_low;
    logic [3:0] addr_high;
    logic [7:0] data_low;
    logic [5:0] data_high;
    eswfr_pkg::eswfr_ctrl_t ctrl;
    logic done;
    logic stall;
    logic busy;
    int num_errors;
    int check_count;
    logic [31:0] seed;
    int ee[int];
    int prog[int];
    int n;
    logic [11:0] pq[$];
    logic [7:0] a;
    logic [7:0] d;
    logic [13:0] w;

    eswfr_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(PW)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .abort_rst_in(abort_rst_in), .cpu_wr_in(cpu_wr_in),
        .done_clr_in(done_clr_in), .prog_we_in(prog_we_in), .prog_addr_in(prog_addr_in),
        .prog_data_in(prog_data_in), .addr_low_reg_out(addr_low), .addr_high_reg_out(addr_high),
        .data_low_reg_out(data_low), .data_high_reg_out(data_high), .nv_control_reg_out(ctrl),
        .write_done_flag_out(done), .stall_out(stall), .pwrt_busy_out(busy)
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic wr(input eswfr_pkg::eswfr_sel_t s, input logic [7:0] v);
        tick;
        cpu_wr_in = {1'b1, s, v};
        tick;
        cpu_wr_in = '0;
    endtask : wr

    task automatic unlock;
        // nothing may interleave with the unlock writes
        wr(eswfr_pkg::ESWFR_SEL_UNLOCK, `ESWFR_UNLOCK_KEY1);
        wr(eswfr_pkg::ESWFR_SEL_UNLOCK, `ESWFR_UNLOCK_KEY2);
    endtask : unlock

    // start request that must be ignored
    task automatic refused(input logic [7:0] v);
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, v);
        chk(ctrl.write_start, 1'b0, "start refused");
        chk(done, 1'b0, "no completion");
    endtask : refused

    task automatic ewrite(input logic [7:0] av, input logic [7:0] dv, input bit clr);
        wr(eswfr_pkg::ESWFR_SEL_ADDR_LOW, av);
        wr(eswfr_pkg::ESWFR_SEL_DATA_LOW, dv);
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h04);
        unlock();
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h06);
        n = 0;
        if (clr) begin
            // permit and start both written low mid-cycle
            wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h00);
            n = 2;
        end
        while (ctrl.write_start === 1'b1 && n < 1000) begin
            n++;
            tick;
        end
        ee[av] = dv;
        chk(16'(n), 16'(WC), "write length");
        chk(done, 1'b1, "done at end");
        chk(ctrl.write_permit_bit, !clr, "permit after write");
    endtask : ewrite

    task automatic drd(input logic [7:0] av);
        wr(eswfr_pkg::ESWFR_SEL_ADDR_LOW, av);
        // read start also drops write permit after the update
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h01);
        tick;
        chk(stall, 1'b0, "data read no stall");
        tick;
        chk(data_low, 16'(ee[av]), "read back");
    endtask : drd

    task automatic prd(input logic [11:0] pa);
        wr(eswfr_pkg::ESWFR_SEL_ADDR_HIGH, {4'h0, pa[11:8]});
        wr(eswfr_pkg::ESWFR_SEL_ADDR_LOW, pa[7:0]);
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h81);
        chk(ctrl.read_start, 1'b1, "read start set");
        chk(stall, 1'b0, "first slot runs");
        tick;
        chk(stall, 1'b1, "second slot stolen");
        tick;
        chk(stall, 1'b0, "stall one slot");
        chk(ctrl.read_start, 1'b0, "read start cleared");
        chk({data_high, data_low}, 16'(prog[pa]), "program word");
    endtask : prd

    task automatic clr_done;
        tick;
        done_clr_in = 1'b1;
        tick;
        done_clr_in = 1'b0;
        chk(done, 1'b0, "done cleared");
    endtask : clr_done

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #(25 * 8000);
        num_errors++;
        conclude();
    end

    initial begin
        rst_in = 1'b1;
        abort_rst_in = 1'b0;
        cpu_wr_in = '0;
        done_clr_in = 1'b0;
        prog_we_in = 1'b0;
        prog_addr_in = 12'h000;
        prog_data_in = 14'h0000;
        seed = 32'h0000_0858;
        repeat (16) tick;
        rst_in = 1'b0;
        chk({addr_high, addr_low}, 16'h0000, "address reset");
        chk({data_high, data_low}, 16'h0000, "data reset");
        chk(16'(ctrl), 16'h0000, "control reset");
        chk({done, stall, busy}, 16'h0001, "flags reset");
        $display("test reset done");
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h04);
        unlock();
        refused(8'h06);
        chk(busy, 1'b1, "timer running");
        n = 0;
        while (busy === 1'b1 && n < 200) begin
            n++;
            tick;
        end
        chk(busy, 1'b0, "timer ends");
        $display("test power-up lockout done");
        pq = {12'h000, 12'hfff};
        repeat (6) pq.push_back(12'(rnd()));
        foreach (pq[i]) begin
            tick;
            w = 14'(rnd());
            prog_we_in = 1'b1;
            prog_addr_in = pq[i];
            prog_data_in = w;
            prog[pq[i]] = w;
        end
        tick;
        prog_we_in = 1'b0;
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h00);
        unlock();
        refused(8'h02);
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h04);
        wr(eswfr_pkg::ESWFR_SEL_UNLOCK, `ESWFR_UNLOCK_KEY1);
        wr(eswfr_pkg::ESWFR_SEL_UNLOCK, 8'h00);
        wr(eswfr_pkg::ESWFR_SEL_UNLOCK, `ESWFR_UNLOCK_KEY2);
        refused(8'h06);
        unlock();
        wr(eswfr_pkg::ESWFR_SEL_ADDR_LOW, 8'h3c);
        refused(8'h06);
        wr(eswfr_pkg::ESWFR_SEL_UNLOCK, `ESWFR_UNLOCK_KEY2);
        refused(8'h06);
        unlock();
        refused(8'h86);
        chk(ctrl.space_select_bit, 1'b1, "program selected");
        $display("test refused starts done");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'hff : 8'(rnd());
            d = 8'(rnd());
            ewrite(a, d, i == 1);
            repeat (5) tick;
            chk(done, 1'b1, "done sticky");
            clr_done();
            if (i != 1) begin
                refused(8'h06);
            end
            drd(a);
        end
        $display("test data writes done");
        foreach (pq[i]) prd(pq[i]);
        w = {data_high, data_low};
        repeat (4) tick;
        chk({data_high, data_low}, 16'(w), "data held");
        wr(eswfr_pkg::ESWFR_SEL_DATA_LOW, 8'h5a);
        chk({data_high, data_low}, {2'h0, w[13:8], 8'h5a}, "software data write");
        $display("test program reads done");
        a = 8'(rnd());
        d = 8'(rnd());
        wr(eswfr_pkg::ESWFR_SEL_ADDR_LOW, a);
        wr(eswfr_pkg::ESWFR_SEL_DATA_LOW, d);
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h04);
        unlock();
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h06);
        repeat (3) tick;
        abort_rst_in = 1'b1;
        tick;
        abort_rst_in = 1'b0;
        ee.delete(a);
        chk(ctrl.write_abort_flag, 1'b1, "abort flagged");
        chk({ctrl.write_start, ctrl.write_permit_bit}, 16'h0000, "abort stops write");
        chk({addr_low, data_low}, {a, d}, "regs kept");
        chk(done, 1'b0, "no done on abort");
        wr(eswfr_pkg::ESWFR_SEL_CONTROL, 8'h00);
        chk(ctrl.write_abort_flag, 1'b0, "abort flag cleared");
        $display("test abort done");
        conclude();
    end
endmodule : eswfr_ctrl_test
`default_nettype wire
